//--- rtl/pcc_pkg.sv
// Purpose: constants and carriers for the primary control config bank
// Assumes: bit positions of the 32-bit control word
// Notes: upper bits 31..22 beyond bit 21 handled elsewhere, mode field is an input
package pcc_pkg;
  localparam int unsigned PCC_W = 32;
  localparam int unsigned B_IF_CLR = 21;
  localparam int unsigned B_SINE = 16;
  localparam int unsigned B_AUTOCLR_PH = 13;
  localparam int unsigned B_CLR_PH = 11;
  localparam int unsigned B_LOAD_ARR = 10;
  localparam int unsigned B_OSK_EN = 9;
  localparam int unsigned B_OSK_AUTO = 8;
  localparam int unsigned B_DIG_PD = 7;
  localparam int unsigned B_DAC_PD = 6;
  localparam int unsigned B_REF_PD = 5;
  localparam int unsigned B_AUX_PD = 4;
  localparam int unsigned B_EXT_PD_FAST = 3;
  localparam int unsigned B_AUTO_PD = 2;
  localparam int unsigned B_SDIO_IN = 1;
  localparam int unsigned B_LSB_FIRST = 0;
  // Implemented (writable) bits; others read as zero
  localparam logic [31:0] PCC_MASK = 32'h0023_2FFF;
  localparam logic [31:0] PCC_RESET = 32'h0000_0000;
  // Immediate bits bypass the holding buffer
  localparam logic [31:0] PCC_IMMED = 32'h0000_00A0;
  localparam logic [1:0] MODE_SINGLE_TONE = 2'h1;
  localparam int unsigned FLUSH_CYCLES = 8;

  typedef struct packed {
    logic if_clear;
    logic sine_sel;
    logic phase_sync_clr;
    logic phase_static_clr;
    logic arr_reload;
    logic osk_enable;
    logic osk_auto;
    logic digital_pd;
    logic dac_pd;
    logic ref_pd;
    logic aux_pd;
    logic ext_pd_fast;
    logic auto_pd_active;
    logic flush;
    logic sdio_input_only;
    logic lsb_first;
  } pcc_ctrl_t;
endpackage

//--- rtl/pcc_hold.sv
// Purpose: holding buffer and active copy of the control word
// Assumes: write and update strobes on core_clk
// Notes: immediate bits pass straight to the active copy
`timescale 1ns/10ps
module pcc_hold (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [pcc_pkg::PCC_W-1:0] wr_data,
  input wire logic update,
  input wire logic clr_if_done,
  // Outputs
  output logic [pcc_pkg::PCC_W-1:0] hold_q,
  output logic [pcc_pkg::PCC_W-1:0] active_q
);
  import pcc_pkg::*;
  logic [PCC_W-1:0] hold_reg, hold_next, act_reg, act_next;

  always_comb begin
    hold_next = hold_reg;
    act_next = act_reg;
    if (clr_if_done) begin
      hold_next[B_IF_CLR] = 1'b0;
      act_next[B_IF_CLR] = 1'b0;
    end
    if (wr_en) begin
      hold_next = wr_data & PCC_MASK;
    end
    if (update) begin
      act_next = hold_next;
    end else begin
      act_next = (act_next & ~PCC_IMMED) | (hold_next & PCC_IMMED);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= PCC_RESET;
      act_reg <= PCC_RESET;
    end else begin
      hold_reg <= hold_next;
      act_reg <= act_next;
    end
  end

  assign hold_q = hold_reg;
  assign active_q = act_reg;
endmodule

//--- rtl/pcc_top.sv
// Purpose: lower control bits of the primary control config register
// Assumes: serial port decoder delivers whole words on core_clk
// Notes: mode field and profile change come from neighbouring logic
// What this block does
// - Clear bit resets interpolation filter accumulators through a registered output, then clears itself after 8 cycles.
// - Bit 16 picks sine when set, cosine when clear, only single tone.
// - Bit 13 resets phase accumulator on every update or profile change.
// - Bit 11 holds phase accumulator in static reset.
// - Bit 10 reloads ramp rate timer on update or profile change.
// - Bit 9 enables output shift keying, default off.
// - Bit 8 picks automatic over manual keying, only with bit 9.
// - Bit 7 stops digital core clocks immediately on write.
// - Bit 6 powers down main converter clocks and bias.
// - Bit 5 powers down reference input and PLL immediately.
// - Bit 4 powers down auxiliary converter clocks and bias.
// - Bit 3 picks fast recovery over full power-down for the pin.
// - Bit 2 flushes and stops clocks while transmit enable is low, except in single tone.
// - Bit 1 makes serial data pin input only, three-wire.
// - Bit 0 shifts least significant bit first.
// - Written bits other than 7 and 5 wait in a holding buffer until update or profile change.
// - Mode field 01 means single tone.
`timescale 1ns/10ps
module pcc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial port word access
  input wire logic wr_en,
  input wire logic [pcc_pkg::PCC_W-1:0] wr_data,
  output logic [pcc_pkg::PCC_W-1:0] rd_data,
  // Update sources
  input wire logic io_update,
  input wire logic profile_change,
  // Context
  input wire logic [1:0] operating_mode,
  input wire logic transmit_enable_pin,
  input wire logic external_powerdown_pin,
  // Controls
  output pcc_pkg::pcc_ctrl_t ctrl,
  output logic full_pd,
  output logic fast_pd
);
  import pcc_pkg::*;

  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  logic [1:0] s1_reg, s1_next, s2_reg, s2_next;
  logic txen_s, epd_s;
  always_comb begin
    s1_next = {transmit_enable_pin, external_powerdown_pin};
    s2_next = s1_reg;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle levels: transmit enabled, power-down pin released
      s1_reg <= 2'h2;
      s2_reg <= 2'h2;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  assign txen_s = s2_reg[1];
  assign epd_s = s2_reg[0];

  // ---------------------------------------------
  // Holding buffer and active word
  // ---------------------------------------------
  logic upd;
  logic clr_done;
  logic [PCC_W-1:0] hold_w, act_w;
  assign upd = io_update | profile_change;
  pcc_hold u_hold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .update(upd),
    .clr_if_done(clr_done),
    .hold_q(hold_w),
    .active_q(act_w)
  );

  // ---------------------------------------------
  // Filter clear timing and flush
  // ---------------------------------------------
  logic [3:0] clr_cnt_reg, clr_cnt_next;
  logic [3:0] fl_cnt_reg, fl_cnt_next;
  logic single_tone, auto_pd;
  assign single_tone = (operating_mode == MODE_SINGLE_TONE);
  assign auto_pd = act_w[B_AUTO_PD] & ~single_tone;
  always_comb begin
    clr_cnt_next = 4'h0;
    clr_done = 1'b0;
    if (act_w[B_IF_CLR]) begin
      clr_cnt_next = clr_cnt_reg + 4'h1;
      if (clr_cnt_reg == 4'(FLUSH_CYCLES - 1)) begin
        clr_done = 1'b1; // self clearing after flush
        clr_cnt_next = 4'h0;
      end
    end
    fl_cnt_next = fl_cnt_reg;
    if (!(auto_pd && !txen_s)) begin
      fl_cnt_next = 4'h0;
    end else if (fl_cnt_reg != 4'(FLUSH_CYCLES)) begin
      fl_cnt_next = fl_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt_reg <= 4'h0;
      fl_cnt_reg <= 4'h0;
    end else begin
      clr_cnt_reg <= clr_cnt_next;
      fl_cnt_reg <= fl_cnt_next;
    end
  end

  // ---------------------------------------------
  // Control outputs
  // ---------------------------------------------
  pcc_ctrl_t ctrl_reg, ctrl_next;
  logic full_reg, full_next, fast_reg, fast_next;
  always_comb begin
    ctrl_next.if_clear = act_w[B_IF_CLR];
    ctrl_next.sine_sel = act_w[B_SINE] & single_tone;
    ctrl_next.phase_sync_clr = act_w[B_AUTOCLR_PH] & upd;
    ctrl_next.phase_static_clr = act_w[B_CLR_PH];
    ctrl_next.arr_reload = act_w[B_LOAD_ARR] & upd;
    ctrl_next.osk_enable = act_w[B_OSK_EN];
    ctrl_next.osk_auto = act_w[B_OSK_AUTO] & act_w[B_OSK_EN];
    ctrl_next.digital_pd = act_w[B_DIG_PD];
    ctrl_next.dac_pd = act_w[B_DAC_PD];
    ctrl_next.ref_pd = act_w[B_REF_PD];
    ctrl_next.aux_pd = act_w[B_AUX_PD];
    ctrl_next.ext_pd_fast = act_w[B_EXT_PD_FAST];
    // Clocks stop only after flush completes, restart when pin high
    ctrl_next.auto_pd_active = (fl_cnt_next == 4'(FLUSH_CYCLES));
    ctrl_next.flush = auto_pd & ~txen_s & (fl_cnt_next != 4'(FLUSH_CYCLES));
    ctrl_next.sdio_input_only = act_w[B_SDIO_IN];
    ctrl_next.lsb_first = act_w[B_LSB_FIRST];
    full_next = epd_s & ~act_w[B_EXT_PD_FAST];
    fast_next = epd_s & act_w[B_EXT_PD_FAST];
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '0;
      full_reg <= 1'b0;
      fast_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      full_reg <= full_next;
      fast_reg <= fast_next;
    end
  end
  assign ctrl = ctrl_reg;
  assign full_pd = full_reg;
  assign fast_pd = fast_reg;
  assign rd_data = hold_w & PCC_MASK;
endmodule

//--- testbench/pcc_top_sva.sv
// Purpose: port assertions for the control bank
// Assumes: ctrl lags writes and updates by two edges, operating_mode by one
// Notes: bound into pcc_top
`timescale 1ns/10ps
module pcc_top_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic wr_en,
  input wire logic [pcc_pkg::PCC_W-1:0] wr_data,
  input wire logic [pcc_pkg::PCC_W-1:0] rd_data,
  input wire logic io_update,
  input wire logic profile_change,
  input wire logic [1:0] operating_mode,
  input wire pcc_pkg::pcc_ctrl_t ctrl,
  input wire logic full_pd,
  input wire logic fast_pd
);
  import pcc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_upd;
    (io_update || profile_change) && !wr_en;
  endsequence
  sequence s_idle;
    (!io_update && !profile_change)[*3];
  endsequence
  a_rd_zero: assert property ((rd_data & ~PCC_MASK) == 32'h0)
    else $error("open bits read nonzero");
  a_hold_write: assert property (wr_en |=> rd_data == ($past(wr_data) & PCC_MASK))
    else $error("holding word wrong");
  a_upd_osk: assert property (s_upd |-> ##2 ctrl.osk_enable == $past(rd_data[B_OSK_EN], 2))
    else $error("keying enable not transferred");
  a_osk_waits: assert property (s_idle |-> $stable(ctrl.osk_enable))
    else $error("keying enable moved without update");
  a_auto_gate: assert property (ctrl.osk_auto |-> ctrl.osk_enable)
    else $error("auto keying without enable");
  a_sine_mode: assert property (ctrl.sine_sel |-> $past(operating_mode) == MODE_SINGLE_TONE)
    else $error("sine outside single tone");
  a_dig_imm: assert property (wr_en |-> ##2 ctrl.digital_pd == $past(wr_data[B_DIG_PD], 2))
    else $error("digital power-down not immediate");
  a_ref_imm: assert property (wr_en |-> ##2 ctrl.ref_pd == $past(wr_data[B_REF_PD], 2))
    else $error("reference power-down not immediate");
  a_pd_excl: assert property (!(full_pd && fast_pd))
    else $error("both power-down kinds");
endmodule
bind pcc_top pcc_top_sva pcc_top_sva_i (.core_clk, .rst_n, .wr_en, .wr_data, .rd_data,
  .io_update, .profile_change, .operating_mode, .ctrl, .full_pd, .fast_pd);

//--- testbench/tb_pcc_top.sv
// Purpose: directed bench for the control bank
// Assumes: ctrl settles two edges after an update
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module tb_pcc_top;
  import pcc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic io_update = 1'b0;
  logic profile_change = 1'b0;
  logic transmit_enable_pin = 1'b1;
  logic external_powerdown_pin = 1'b0;
  logic [1:0] operating_mode = 2'h0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic full_pd;
  logic fast_pd;
  pcc_ctrl_t ctrl;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  pcc_top pcc_top_i (.core_clk, .rst_n, .wr_en, .wr_data, .rd_data, .io_update,
    .profile_change, .operating_mode, .transmit_enable_pin, .external_powerdown_pin,
    .ctrl, .full_pd, .fast_pd);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] d);
    wr_en = 1'b1;
    wr_data = d;
    tick(1);
    wr_en = 1'b0;
  endtask
  task automatic upd(input logic pc);
    profile_change = pc;
    io_update = !pc;
    tick(1);
    io_update = 1'b0;
    profile_change = 1'b0;
    tick(2);
  endtask
  task automatic t_hold;
    chk("ctrl", 32'(ctrl), 32'h0);
    wr(32'hFFFF_FFFF);
    chk("rd_data", rd_data, PCC_MASK);
    tick(2);
    chk("osk_en", ctrl.osk_enable, 1'b0);
    chk("imm", {ctrl.digital_pd, ctrl.ref_pd}, 2'h3);
    upd(1'b0);
    chk("osk", {ctrl.osk_enable, ctrl.osk_auto, ctrl.sine_sel}, 3'h6);
    chk("pd", {ctrl.dac_pd, ctrl.aux_pd, ctrl.ext_pd_fast}, 3'h7);
    chk("port", {ctrl.sdio_input_only, ctrl.lsb_first, ctrl.phase_static_clr}, 3'h7);
    wr(32'h0);
    upd(1'b1);
    chk("ctrl", 32'(ctrl), 32'h0);
    $display("t_hold done");
  endtask
  task automatic t_sine;
    wr(32'h0001_0100);
    upd(1'b0);
    chk("sine", {ctrl.sine_sel, ctrl.osk_auto}, 2'h0);
    operating_mode = 2'h1;
    tick(2);
    chk("sine", ctrl.sine_sel, 1'b1);
    wr(32'h0);
    upd(1'b0);
    operating_mode = 2'h0;
    $display("t_sine done");
  endtask
  task automatic t_pd;
    wr(32'h8);
    upd(1'b0);
    external_powerdown_pin = 1'b1;
    tick(4);
    chk("pd", {full_pd, fast_pd}, 2'h1);
    wr(32'h0);
    upd(1'b0);
    tick(1);
    chk("pd", {full_pd, fast_pd}, 2'h2);
    external_powerdown_pin = 1'b0;
    $display("t_pd done");
  endtask
  task automatic t_auto;
    wr(32'h0020_2404);
    upd(1'b0);
    chk("if_clear", ctrl.if_clear, 1'b1);
    io_update = 1'b1;
    tick(1);
    io_update = 1'b0;
    chk("pulses", {ctrl.phase_sync_clr, ctrl.arr_reload}, 2'h3);
    tick(1);
    chk("pulses", {ctrl.phase_sync_clr, ctrl.arr_reload}, 2'h0);
    tick(10);
    chk("if_clear", ctrl.if_clear, 1'b0);
    chk("rd_data", rd_data, 32'h0000_2404);
    transmit_enable_pin = 1'b0;
    tick(4);
    chk("flush", {ctrl.flush, ctrl.auto_pd_active}, 2'h2);
    tick(10);
    chk("flush", {ctrl.flush, ctrl.auto_pd_active}, 2'h1);
    transmit_enable_pin = 1'b1;
    tick(4);
    chk("flush", {ctrl.flush, ctrl.auto_pd_active}, 2'h0);
    wr(32'h0);
    upd(1'b0);
    $display("t_auto done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(4);
    rst_n = 1'b1;
    tick(1);
    t_hold();
    t_sine();
    t_pd();
    t_auto();
    results();
  end
endmodule
